//--- rtl/pwr_mode_pkg.sv
/*
 * Constants, types and timing counts for the battery monitor power mode controller.
 * Assumes a 40 MHz core clock; all counts are derived from it here.
 */
package pwr_mode_pkg;

   localparam int unsigned CLK_HZ         = 40_000_000;
   localparam int unsigned CUR_PERIOD_US  = 3_000;
   localparam int unsigned VOLT_PERIOD_US = 63_000;
   localparam int unsigned SLP_CUR_US     = 12_000;
   localparam int unsigned SECOND_US      = 1_000_000;
   localparam int unsigned DEEP_EXIT_US   = 250_000;
   localparam int unsigned CUR_CYC        = (CLK_HZ / 1_000_000) * CUR_PERIOD_US;
   localparam int unsigned VOLT_CYC       = (CLK_HZ / 1_000_000) * VOLT_PERIOD_US;
   localparam int unsigned SLP_CUR_CYC    = (CLK_HZ / 1_000_000) * SLP_CUR_US;
   localparam int unsigned SECOND_CYC     = (CLK_HZ / 1_000_000) * SECOND_US;
   localparam int unsigned DEEP_EXIT_CYC  = (CLK_HZ / 1_000_000) * DEEP_EXIT_US;

   localparam logic [1:0] OSC_SLOW_FAST = 2'h0;
   localparam logic [1:0] OSC_SLOW_LOW  = 2'h1;
   localparam logic [1:0] OSC_SLOW_OFF  = 2'h2;

   typedef enum logic [2:0] {
      MODE_NORMAL  = 3'b000,
      MODE_SLEEP   = 3'b001,
      MODE_DEEP    = 3'b010,
      MODE_DEEPEX  = 3'b011,
      MODE_SHUT    = 3'b100,
      MODE_CFGUPD  = 3'b101
   } mode_type;

   typedef enum logic [2:0] {
      CMD_NONE       = 3'h0,
      CMD_SLEEP_ALLOW = 3'h1,
      CMD_SLEEP_BLOCK = 3'h2,
      CMD_SLEEP_EXIT = 3'h3,
      CMD_DEEP_ENTER = 3'h4,
      CMD_DEEP_EXIT  = 3'h5,
      CMD_CFG_ENTER  = 3'h6,
      CMD_CFG_EXIT   = 3'h7
   } cmd_type;

   typedef struct packed {
      logic sleep_allow_boot;
      logic fast_conv;
      logic slp_chg_on;
      logic slp_dsg_follower;
      logic deep_aux_regulator_one_keep;
      logic deep_aux_regulator_two_keep;
      logic deep_slow_osc_keep;
      logic [2:0] hyst_sec;
      logic [7:0] slp_interval_sec;
      logic [1:0] volt_slow_mult;
   } cfg_type;

   typedef struct packed {
      logic relax;
      logic slp_cur_over;
      logic pack_wake;
      logic fault;
      logic charger;
      logic rst_short;
      logic load_rise;
      logic supply_low;
      logic loop_done;
   } cond_type;

   typedef struct packed {
      logic chg_on;
      logic precharge_fet_on;
      logic dsg_on;
      logic predischarge_fet_on;
      logic dsg_follower;
   } fet_type;

endpackage : pwr_mode_pkg

//--- rtl/tick_timer.sv
/*
 * Period counter, running while run_i is high, giving a one-cycle tick every PERIOD cycles.
 * Assumes the single core clock; clear restarts the period.
 */
`timescale 1ns/10ps
`default_nettype none
module tick_timer #(
   parameter int unsigned PERIOD = 120_000,
   parameter int unsigned WIDTH  = 26
) (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   // control
   input  wire logic run_i,
   input  wire logic clear_i,
   output logic      tick_o
);
   logic [WIDTH-1:0] cnt_ff;
   logic [WIDTH-1:0] nxt_cnt;
   logic             last;

   assign last   = (cnt_ff == WIDTH'(PERIOD - 1));
   assign tick_o = run_i && last;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (clear_i || !run_i || last) begin
         nxt_cnt = '0;
      end else begin
         nxt_cnt = cnt_ff + WIDTH'(1);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule : tick_timer
`default_nettype wire

//--- rtl/event_counter.sv
/*
 * Counts ticks up to a runtime limit and flags reaching it.
 * Assumes ticks are one-cycle pulses on the core clock.
 */
`timescale 1ns/10ps
`default_nettype none
module event_counter #(
   parameter int unsigned WIDTH = 8
) (
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             rst_n_i,
   // control
   input  wire logic             clear_i,
   input  wire logic             tick_i,
   input  wire logic [WIDTH-1:0] limit_i,
   output logic                  reached_o
);
   logic [WIDTH-1:0] cnt_ff;
   logic [WIDTH-1:0] nxt_cnt;

   assign reached_o = (cnt_ff >= limit_i);

   always_comb begin
      nxt_cnt = cnt_ff;
      if (clear_i) begin
         nxt_cnt = '0;
      end else if (tick_i && !reached_o) begin
         nxt_cnt = cnt_ff + WIDTH'(1);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule : event_counter
`default_nettype wire

//--- rtl/pwr_mode_ctrl.sv
/*
 * Functional power mode controller: normal, sleep, deep low-power, shutdown and
 * parameter update. Drives fet enables, measurement strobes, regulator and
 * oscillator enables. Assumes measured conditions arrive as synchronous levels
 * or pulses from the analog front end and commands as one-cycle strobes.
 */
`timescale 1ns/10ps
`default_nettype none
module pwr_mode_ctrl
   import pwr_mode_pkg::*;
#(
   parameter int unsigned SECOND_CYCLES    = SECOND_CYC,
   parameter int unsigned CUR_CYCLES       = CUR_CYC,
   parameter int unsigned VOLT_CYCLES      = VOLT_CYC,
   parameter int unsigned SLP_CUR_CYCLES   = SLP_CUR_CYC,
   parameter int unsigned DEEP_EXIT_CYCLES = DEEP_EXIT_CYC
) (
   // clock and reset
   input  wire logic     mclk_i,
   input  wire logic     rst_n_i,
   // configuration and host commands
   input  wire cfg_type  cfg_i,
   input  wire cmd_type  cmd_i,
   // measured conditions
   input  wire cond_type cond_i,
   input  wire logic     prot_ok_i,
   // fet drive and protections
   output fet_type       fet_o,
   output logic          prot_en_o,
   output logic          temp_prot_upd_o,
   // measurement strobes
   output logic          meas_cur_o,
   output logic          meas_volt_o,
   output logic          meas_cc2_o,
   output logic          meas_interval_o,
   output logic          cc_lowpower_o,
   output logic          loop_start_o,
   // supplies and oscillators
   output logic          aux_regulator_one_en_o,
   output logic          aux_regulator_two_en_o,
   output logic          fast_osc_en_o,
   output logic [1:0]    slow_osc_o,
   // status
   output mode_type      mode_o,
   output logic          sleep_allowed_o,
   output logic          sleeping_o
);
   ////////////////////////////////////////////////////////////////////////////
   // timers
   logic     sec_tick;
   logic     cur_tick;
   logic     volt_tick;
   logic     slp_cur_tick;
   logic     deep_tick;
   logic     hyst_done;
   logic     interval_done;
   logic     deep_wait_done;
   mode_type mode_ff;
   mode_type nxt_mode;
   logic     run_normal;
   logic     run_sleep;
   logic     mode_change;

   assign run_normal  = (mode_ff == MODE_NORMAL);
   assign run_sleep   = (mode_ff == MODE_SLEEP);
   assign mode_change = (nxt_mode != mode_ff);

   tick_timer #(.PERIOD(SECOND_CYCLES), .WIDTH(26)) u_sec (
      .mclk_i (mclk_i),
      .rst_n_i(rst_n_i),
      .run_i  (1'b1),
      .clear_i(1'b0),
      .tick_o (sec_tick)
   );

   tick_timer #(.PERIOD(CUR_CYCLES), .WIDTH(26)) u_cur (
      .mclk_i (mclk_i),
      .rst_n_i(rst_n_i),
      .run_i  (run_normal),
      .clear_i(mode_change),
      .tick_o (cur_tick)
   );

   tick_timer #(.PERIOD(VOLT_CYCLES / 2), .WIDTH(26)) u_volt (
      .mclk_i (mclk_i),
      .rst_n_i(rst_n_i),
      .run_i  (run_normal),
      .clear_i(mode_change),
      .tick_o (volt_tick)
   );

   tick_timer #(.PERIOD(SLP_CUR_CYCLES), .WIDTH(26)) u_slpcur (
      .mclk_i (mclk_i),
      .rst_n_i(rst_n_i),
      .run_i  (run_sleep),
      .clear_i(mode_change),
      .tick_o (slp_cur_tick)
   );

   tick_timer #(.PERIOD(DEEP_EXIT_CYCLES), .WIDTH(26)) u_deepx (
      .mclk_i (mclk_i),
      .rst_n_i(rst_n_i),
      .run_i  (mode_ff == MODE_DEEPEX),
      .clear_i(mode_change),
      .tick_o (deep_tick)
   );

   // sleep hysteresis after any return to normal
   event_counter #(.WIDTH(3)) u_hyst (
      .mclk_i   (mclk_i),
      .rst_n_i  (rst_n_i),
      .clear_i  (mode_change && nxt_mode == MODE_NORMAL),
      .tick_i   (sec_tick),
      .limit_i  (cfg_i.hyst_sec),
      .reached_o(hyst_done)
   );

   // sleep measurement interval in seconds
   event_counter #(.WIDTH(8)) u_intv (
      .mclk_i   (mclk_i),
      .rst_n_i  (rst_n_i),
      .clear_i  (!run_sleep || interval_done),
      .tick_i   (sec_tick),
      .limit_i  (cfg_i.slp_interval_sec),
      .reached_o(interval_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // cadence counters for voltage slow-down and half-rate division
   logic [1:0] volt_div_ff;
   logic [1:0] nxt_volt_div;
   logic       half_ff;
   logic       nxt_half;
   logic       volt_due;
   logic [1:0] volt_limit;

   // fast conversion doubles the rate: use every half-period tick
   assign volt_limit = cfg_i.volt_slow_mult;
   assign volt_due   = volt_tick && (cfg_i.fast_conv || half_ff) &&
                       (volt_div_ff == volt_limit);

   always_comb begin
      nxt_half     = half_ff;
      nxt_volt_div = volt_div_ff;
      if (!run_normal) begin
         nxt_half     = 1'b0;
         nxt_volt_div = 2'h0;
      end else if (volt_tick) begin
         nxt_half = !half_ff;
         if (cfg_i.fast_conv || half_ff) begin
            nxt_volt_div = (volt_div_ff == volt_limit) ? 2'h0 : volt_div_ff + 2'h1;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         half_ff     <= 1'b0;
         volt_div_ff <= 2'h0;
      end else begin
         half_ff     <= nxt_half;
         volt_div_ff <= nxt_volt_div;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sleep permission, loop restart pending after current-flow exit
   logic sleep_allow_ff;
   logic nxt_sleep_allow;
   logic boot_ff;
   logic nxt_boot;
   logic loop_wait_ff;
   logic nxt_loop_wait;
   logic slp_exit_cur;

   assign slp_exit_cur = cond_i.slp_cur_over ||
                         (interval_done && cond_i.slp_cur_over);

   always_comb begin
      nxt_boot        = 1'b0;
      nxt_sleep_allow = sleep_allow_ff;
      if (boot_ff) begin
         nxt_sleep_allow = cfg_i.sleep_allow_boot;
      end else if (cmd_i == CMD_SLEEP_ALLOW) begin
         nxt_sleep_allow = 1'b1;
      end else if (cmd_i == CMD_SLEEP_BLOCK) begin
         nxt_sleep_allow = 1'b0;
      end
      nxt_loop_wait = loop_wait_ff;
      if (run_sleep && slp_exit_cur) begin
         nxt_loop_wait = 1'b1;
      end else if (sec_tick || mode_ff != MODE_NORMAL) begin
         nxt_loop_wait = 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         boot_ff        <= 1'b1;
         sleep_allow_ff <= 1'b0;
         loop_wait_ff   <= 1'b0;
      end else begin
         boot_ff        <= nxt_boot;
         sleep_allow_ff <= nxt_sleep_allow;
         loop_wait_ff   <= nxt_loop_wait;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode state machine
   always_comb begin
      nxt_mode = mode_ff;
      unique case (mode_ff)
         MODE_NORMAL: begin
            if (cmd_i == CMD_CFG_ENTER) begin
               nxt_mode = MODE_CFGUPD;
            end else if (cmd_i == CMD_DEEP_ENTER) begin
               nxt_mode = MODE_DEEP;
            end else if (cond_i.relax && sleep_allow_ff && hyst_done && !boot_ff) begin
               nxt_mode = MODE_SLEEP;
            end
         end
         MODE_SLEEP: begin
            if (cond_i.fault || slp_exit_cur || cond_i.charger || cond_i.rst_short ||
                cmd_i == CMD_SLEEP_EXIT || !sleep_allow_ff ||
                (interval_done && cond_i.pack_wake)) begin
               nxt_mode = MODE_NORMAL;
            end else if (cmd_i == CMD_DEEP_ENTER) begin
               nxt_mode = MODE_DEEP;
            end
         end
         MODE_DEEP: begin
            if (cond_i.supply_low) begin
               nxt_mode = MODE_SHUT;
            end else if (cmd_i == CMD_DEEP_EXIT || cond_i.rst_short || cond_i.load_rise) begin
               nxt_mode = MODE_DEEPEX;
            end
         end
         MODE_DEEPEX: begin
            if (deep_wait_done && cond_i.loop_done && prot_ok_i) begin
               nxt_mode = MODE_NORMAL;
            end
         end
         MODE_SHUT: begin
            nxt_mode = MODE_SHUT;
         end
         MODE_CFGUPD: begin
            if (cmd_i == CMD_CFG_EXIT) begin
               nxt_mode = MODE_NORMAL;
            end
         end
         default: begin
            nxt_mode = MODE_NORMAL;
         end
      endcase
   end

   // deep exit waits the settling time, then the full loop
   logic deep_wait_ff;
   logic nxt_deep_wait;

   assign deep_wait_done = deep_wait_ff;

   always_comb begin
      nxt_deep_wait = deep_wait_ff;
      if (mode_ff != MODE_DEEPEX) begin
         nxt_deep_wait = 1'b0;
      end else if (deep_tick) begin
         nxt_deep_wait = 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         mode_ff      <= MODE_NORMAL;
         deep_wait_ff <= 1'b0;
      end else begin
         mode_ff      <= nxt_mode;
         deep_wait_ff <= nxt_deep_wait;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, registered from the mode
   fet_type    nxt_fet;
   logic       nxt_prot;
   logic       nxt_aux_regulator_one;
   logic       nxt_aux_regulator_two;
   logic [1:0] nxt_slow;
   fet_type    fet_ff;
   logic       prot_ff;
   logic       aux_regulator_one_ff;
   logic       aux_regulator_two_ff;
   logic [1:0] slow_ff;

   always_comb begin
      nxt_fet  = '0;
      nxt_prot = 1'b0;
      nxt_aux_regulator_one = 1'b0;
      nxt_aux_regulator_two = 1'b0;
      nxt_slow = OSC_SLOW_OFF;
      unique case (nxt_mode)
         MODE_NORMAL: begin
            nxt_fet  = '{chg_on: 1'b1, precharge_fet_on: 1'b1, dsg_on: 1'b1, predischarge_fet_on: 1'b1,
                         dsg_follower: 1'b0};
            nxt_prot = 1'b1;
            nxt_aux_regulator_one = 1'b1;
            nxt_aux_regulator_two = 1'b1;
            nxt_slow = OSC_SLOW_FAST;
         end
         MODE_SLEEP: begin
            nxt_fet.dsg_on       = 1'b1;
            nxt_fet.dsg_follower = cfg_i.slp_dsg_follower;
            nxt_fet.chg_on       = cfg_i.slp_chg_on;
            nxt_prot = 1'b1;
            nxt_aux_regulator_one = 1'b1;
            nxt_aux_regulator_two = 1'b1;
            nxt_slow = OSC_SLOW_LOW;
         end
         MODE_DEEP, MODE_DEEPEX: begin
            nxt_aux_regulator_one = cfg_i.deep_aux_regulator_one_keep;
            nxt_aux_regulator_two = cfg_i.deep_aux_regulator_two_keep;
            nxt_slow = cfg_i.deep_slow_osc_keep ? OSC_SLOW_LOW : OSC_SLOW_OFF;
            nxt_prot = (nxt_mode == MODE_DEEPEX);
         end
         MODE_SHUT: begin
            nxt_slow = OSC_SLOW_OFF;
         end
         MODE_CFGUPD: begin
            nxt_aux_regulator_one = 1'b1;
            nxt_aux_regulator_two = 1'b1;
            nxt_slow = OSC_SLOW_FAST;
         end
         default: begin
            nxt_slow = OSC_SLOW_OFF;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         fet_ff  <= '0;
         prot_ff <= 1'b0;
         aux_regulator_one_ff <= 1'b0;
         aux_regulator_two_ff <= 1'b0;
         slow_ff <= OSC_SLOW_FAST;
      end else begin
         fet_ff  <= nxt_fet;
         prot_ff <= nxt_prot;
         aux_regulator_one_ff <= nxt_aux_regulator_one;
         aux_regulator_two_ff <= nxt_aux_regulator_two;
         slow_ff <= nxt_slow;
      end
   end

   assign fet_o      = fet_ff;
   assign prot_en_o  = prot_ff;
   assign aux_regulator_one_en_o  = aux_regulator_one_ff;
   assign aux_regulator_two_en_o  = aux_regulator_two_ff;
   assign slow_osc_o = slow_ff;
   assign mode_o     = mode_ff;

   // measurement strobes; none while deep, shutdown or updating
   assign meas_cur_o      = cur_tick && !loop_wait_ff;
   assign meas_volt_o     = volt_due && !loop_wait_ff;
   assign meas_cc2_o      = volt_due && !loop_wait_ff;
   assign meas_interval_o = run_sleep && interval_done;
   assign temp_prot_upd_o = meas_interval_o || meas_volt_o;
   assign cc_lowpower_o   = run_sleep && slp_cur_tick;
   assign loop_start_o    = (mode_ff == MODE_DEEPEX) && deep_tick;
   assign fast_osc_en_o   = meas_cur_o || meas_volt_o || meas_interval_o ||
                            cc_lowpower_o || loop_start_o || (cmd_i != CMD_NONE);
   assign sleep_allowed_o = sleep_allow_ff;
   assign sleeping_o      = run_sleep;
endmodule : pwr_mode_ctrl
`default_nettype wire

//--- bench/pwr_mode_checker.sv
/* assertions on the ports of the power mode controller.
   assumes one clock domain and a bind to every pwr_mode_ctrl */
`timescale 1ns/10ps
`default_nettype none
module pwr_mode_checker
   import pwr_mode_pkg::*;
(
   // clock and reset
   input wire logic     mclk_i,
   input wire logic     rst_n_i,
   // commands and conditions
   input wire cmd_type  cmd_i,
   input wire cond_type cond_i,
   input wire logic     prot_ok_i,
   // controller outputs
   input wire fet_type  fet_o,
   input wire logic     prot_en_o,
   input wire logic     meas_cur_o,
   input wire logic     aux_regulator_one_en_o,
   input wire logic     aux_regulator_two_en_o,
   input wire mode_type mode_o,
   input wire logic     sleep_allowed_o,
   input wire logic     sleeping_o
);
default clocking main_cb @(posedge mclk_i); endclocking
default disable iff (!rst_n_i);
////////////////////////////////////////
sequence deep_wake_s;
   mode_o == MODE_DEEP && !cond_i.supply_low && (cmd_i == CMD_DEEP_EXIT || cond_i.rst_short || cond_i.load_rise);
endsequence
sequence sleep_wake_s;
   mode_o == MODE_SLEEP && (cond_i.fault || cond_i.charger || cond_i.slp_cur_over || cmd_i == CMD_SLEEP_EXIT);
endsequence
////////////////////////////////////////
deep_fets_a: assert property (mode_o == MODE_DEEP |-> fet_o == '0 && !prot_en_o)
   else $error("fets or protections on in deep mode");
shut_off_a: assert property (mode_o == MODE_SHUT |-> fet_o == '0 && !aux_regulator_one_en_o && !aux_regulator_two_en_o)
   else $error("shutdown leaves a fet or regulator on");
sleep_fets_a: assert property (mode_o == MODE_SLEEP |-> fet_o.dsg_on && prot_en_o)
   else $error("sleep without discharge fet or protections");
deep_hold_a: assert property (mode_o == MODE_DEEP && cmd_i != CMD_DEEP_EXIT && !cond_i.rst_short
   && !cond_i.load_rise && !cond_i.supply_low |=> mode_o == MODE_DEEP) else $error("deep mode left unasked");
deep_wake_a: assert property (deep_wake_s |=> mode_o == MODE_DEEPEX)
   else $error("deep mode wake ignored");
deep_low_a: assert property (mode_o == MODE_DEEP && cond_i.supply_low |=> mode_o == MODE_SHUT)
   else $error("low supply did not shut down");
deep_loop_a: assert property (mode_o == MODE_DEEPEX && !(cond_i.loop_done && prot_ok_i)
   |=> mode_o != MODE_NORMAL) else $error("normal mode before exit loop passed");
sleep_wake_a: assert property (sleep_wake_s |=> mode_o == MODE_NORMAL)
   else $error("sleep wake ignored");
sleep_block_a: assert property (mode_o == MODE_NORMAL && !sleep_allowed_o && cmd_i != CMD_SLEEP_ALLOW
   |=> mode_o != MODE_SLEEP) else $error("sleep entered while blocked");
sleep_flag_a: assert property (sleeping_o == (mode_o == MODE_SLEEP))
   else $error("sleeping flag disagrees with mode");
cfg_halt_a: assert property (mode_o == MODE_CFGUPD |-> !meas_cur_o && !prot_en_o)
   else $error("activity during parameter update");
endmodule : pwr_mode_checker
bind pwr_mode_ctrl pwr_mode_checker u_pwr_mode_checker (.mclk_i, .rst_n_i, .cmd_i, .cond_i, .prot_ok_i,
   .fet_o, .prot_en_o, .meas_cur_o, .aux_regulator_one_en_o, .aux_regulator_two_en_o, .mode_o, .sleep_allowed_o, .sleeping_o);
`default_nettype wire

//--- bench/host_model.sv
/* host processor issuing one-cycle subcommands.
   assumes callers act at falling edges of the core clock */
`timescale 1ns/10ps
`default_nettype none
module host_model
   import pwr_mode_pkg::*;
(
   // clock
   input wire logic mclk_i,
   // subcommand strobe
   output cmd_type  cmd_o
);
initial cmd_o = CMD_NONE;
// deep mode is only ever asked for through this strobe
task automatic send(input cmd_type c);
   cmd_o = c;
   @(negedge mclk_i);
   cmd_o = CMD_NONE;
   @(negedge mclk_i);
endtask : send
endmodule : host_model
`default_nettype wire

//--- bench/pwr_mode_ctrl_test.sv
/* self-checking bench for the power mode controller.
   assumes shortened counts and a host model on the command port */
`timescale 1ns/10ps
`default_nettype none
module pwr_mode_ctrl_test;
import pwr_mode_pkg::*;
localparam int unsigned SEC = 40;
localparam int unsigned VOLT = 8;
localparam int unsigned DEEPX = 10;
localparam int unsigned SLPCUR = 6;
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
   $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
logic     mclk_i = 1'b0;
logic     rst_n_i = 1'b0;
cfg_type  cfg_i;
cond_type cond_i = '0;
logic     prot_ok_i = 1'b0;
cmd_type  cmd_i;
fet_type  fet_o;
mode_type mode_o;
logic     prot_en_o, meas_cur_o, meas_volt_o, loop_start_o, aux_regulator_one_en_o, aux_regulator_two_en_o;
logic     sleep_allowed_o, sleeping_o;
logic     meas_cc2_o, meas_interval_o, cc_lowpower_o, temp_prot_upd_o, fast_osc_en_o;
logic [1:0] slow_osc_o;
int       num_errors = 0;
int       tests_run = 0;
int       nc, nv, n, nl, ni, nt, n2;
int       slp_causes[6] = '{7, 6, 5, 4, 3, -1};
int       deep_causes[3] = '{-2, 3, 2};
always #12.5 mclk_i = ~mclk_i;
host_model u_host_model (.mclk_i, .cmd_o(cmd_i));
pwr_mode_ctrl #(.SECOND_CYCLES(SEC), .CUR_CYCLES(4), .VOLT_CYCLES(VOLT), .SLP_CUR_CYCLES(SLPCUR),
   .DEEP_EXIT_CYCLES(DEEPX)) u_pwr_mode_ctrl (.mclk_i, .rst_n_i, .cfg_i, .cmd_i, .cond_i, .prot_ok_i,
   .fet_o, .prot_en_o, .temp_prot_upd_o, .meas_cur_o, .meas_volt_o, .meas_cc2_o, .meas_interval_o,
   .cc_lowpower_o, .loop_start_o, .aux_regulator_one_en_o, .aux_regulator_two_en_o, .fast_osc_en_o, .slow_osc_o, .mode_o,
   .sleep_allowed_o, .sleeping_o);
////////////////////////////////////////
function automatic int exp_volt(cfg_type c);
   return 96 / ((VOLT * (c.volt_slow_mult + 1)) >> c.fast_conv);
endfunction : exp_volt
task automatic print_verdict;
   if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
   else $display("STATUS NOT OK");
   $finish;
endtask : print_verdict
task automatic wait_mode(input mode_type m, input int lim);
   n = 0;
   while (mode_o !== m && n < lim) begin
      @(negedge mclk_i);
      n++;
   end
   `CHK("mode", m, mode_o)
   if (mode_o !== m) print_verdict();
endtask : wait_mode
task automatic count_strobes(input int cyc);
   nc = 0;
   nv = 0;
   nl = 0;
   ni = 0;
   nt = 0;
   n2 = 0;
   repeat (cyc) begin
      @(negedge mclk_i);
      nc += int'(meas_cur_o);
      nv += int'(meas_volt_o);
      nl += int'(cc_lowpower_o);
      ni += int'(meas_interval_o);
      nt += int'(temp_prot_upd_o);
      n2 += int'(meas_cc2_o);
   end
endtask : count_strobes
task automatic wake(input int idx, input mode_type m);
   if (idx == -1) u_host_model.send(CMD_SLEEP_EXIT);
   else if (idx == -2) u_host_model.send(CMD_DEEP_EXIT);
   else cond_i[idx] = 1'b1;
   wait_mode(m, 200);
   if (idx >= 0) cond_i[idx] = 1'b0;
endtask : wake
////////////////////////////////////////
initial begin
   repeat (20000) @(posedge mclk_i);
   num_errors++;
   $display("mismatch run length expected end seen hang");
   print_verdict();
end
initial begin
   void'($urandom(32'hDA4A5166));
   cfg_i = cfg_type'($urandom);
   cfg_i.sleep_allow_boot = 1'b1;
   cfg_i.hyst_sec = 3'h0;
   cfg_i.slp_interval_sec = 8'h01;
   repeat (12) @(negedge mclk_i);
   rst_n_i = 1'b1;
   repeat (2) @(negedge mclk_i);
   `CHK("allowed", 1'b1, sleep_allowed_o)
   `CHK("slow osc", OSC_SLOW_FAST, slow_osc_o)
   for (int i = 0; i < 2; i++) begin
      cfg_i.fast_conv = i[0];
      cfg_i.volt_slow_mult = 2'($urandom);
      repeat (40) @(negedge mclk_i);
      count_strobes(96);
      `CHK("cur strobes", 24, nc)
      `CHK("volt strobes", exp_volt(cfg_i), nv)
      `CHK("cc2 strobes", exp_volt(cfg_i), n2)
   end
   foreach (slp_causes[k]) begin
      cfg_i.slp_chg_on = 1'($urandom);
      cfg_i.slp_dsg_follower = 1'($urandom);
      cond_i.relax = 1'b1;
      wait_mode(MODE_SLEEP, 20);
      cond_i.relax = 1'b0;
      `CHK("sleeping", 1'b1, sleeping_o)
      `CHK("chg", cfg_i.slp_chg_on, fet_o.chg_on)
      `CHK("follower", cfg_i.slp_dsg_follower, fet_o.dsg_follower)
      `CHK("slow osc", OSC_SLOW_LOW, slow_osc_o)
      count_strobes(3 * SEC);
      `CHK("sleep cc samples", 3 * SEC / SLPCUR, nl)
      `CHK("sleep intervals", 3, ni)
      `CHK("sleep temp upd", 3, nt)
      `CHK("sleep strobes", 0, nc + nv)
      wake(slp_causes[k], MODE_NORMAL);
      `CHK("fets back", 2'b10, {fet_o.chg_on, fet_o.dsg_follower})
   end
   cond_i.relax = 1'b1;
   wait_mode(MODE_SLEEP, 20);
   cfg_i.hyst_sec = 3'h2;
   wake(5, MODE_NORMAL);
   count_strobes(SEC - 2);
   `CHK("hysteresis", MODE_NORMAL, mode_o)
   wait_mode(MODE_SLEEP, 3 * SEC);
   cfg_i.hyst_sec = 3'h0;
   u_host_model.send(CMD_SLEEP_BLOCK);
   wait_mode(MODE_NORMAL, 4);
   count_strobes(20);
   `CHK("blocked", 2'b00, {sleep_allowed_o, sleeping_o})
   cond_i.relax = 1'b0;
   u_host_model.send(CMD_SLEEP_ALLOW);
   wait_mode(MODE_NORMAL, 20);
   `CHK("allowed again", 1'b1, sleep_allowed_o)
   foreach (deep_causes[k]) begin
      cfg_i = cfg_type'($urandom & 32'h0000E000);
      prot_ok_i = 1'b0;
      u_host_model.send(CMD_DEEP_ENTER);
      wait_mode(MODE_DEEP, 4);
      `CHK("regs", {cfg_i.deep_aux_regulator_one_keep, cfg_i.deep_aux_regulator_two_keep}, {aux_regulator_one_en_o, aux_regulator_two_en_o})
      `CHK("slow osc", cfg_i.deep_slow_osc_keep ? OSC_SLOW_LOW : OSC_SLOW_OFF, slow_osc_o)
      u_host_model.send(CMD_SLEEP_EXIT);
      u_host_model.send(CMD_CFG_ENTER);
      `CHK("deep stays", MODE_DEEP, mode_o)
      wake(deep_causes[k], MODE_DEEPEX);
      n = 0;
      while (loop_start_o !== 1'b1 && n < 50) begin
         @(negedge mclk_i);
         n++;
      end
      `CHK("loop start", 1'b1, loop_start_o && n >= DEEPX - 3)
      cond_i.loop_done = 1'b1;
      repeat (3) @(negedge mclk_i);
      `CHK("exit held", MODE_DEEPEX, mode_o)
      prot_ok_i = 1'b1;
      wait_mode(MODE_NORMAL, 4);
      cond_i.loop_done = 1'b0;
   end
   u_host_model.send(CMD_CFG_ENTER);
   wait_mode(MODE_CFGUPD, 4);
   count_strobes(20);
   `CHK("update strobes", 0, nc)
   u_host_model.send(CMD_CFG_EXIT);
   wait_mode(MODE_NORMAL, 4);
   u_host_model.send(CMD_DEEP_ENTER);
   cond_i.supply_low = 1'b1;
   wait_mode(MODE_SHUT, 6);
   `CHK("shut outputs", 8'h00, {fet_o, prot_en_o, aux_regulator_one_en_o, aux_regulator_two_en_o})
   `CHK("fast osc", 1'b0, fast_osc_en_o)
   print_verdict();
end
endmodule : pwr_mode_ctrl_test
`default_nettype wire
